// ---- hw/rtcfg_top.sv ----
// Contract
// - Two independent per-terminal configuration registers
// - Select field picks dead time 15/20/58/138us
// - Same field picks RT-RT 57/62/100/180us
// - RT-RT timed parity of command to sync
// - RT-RT span includes two 20us embedded words
// - Bus A inhibit bit blocks this terminal only
// - Bus B inhibit bit blocks this terminal only
// - Scope option: both directions or transmit only
// - Global pin or bit still blocks transmit
// - Broadcast invalid: address 31 ignored entirely
// - Broadcast valid: address 31 processed
// - Undefined-mode bit covers listed codes only
// - Legal undefined mode answered, status updated
// - Illegal undefined mode: error, status only
// - Undefined-mode invalid: listed codes ignored
// - Master reset clears upper field
// - Separate broadcast storage when bit set
// - Shared storage when bit clear
//
// Implementation choice: the AHB-Lite register port.
`default_nettype none
module rtcfg_top
  import rtcfg_pkg::*;
#(
  parameter int unsigned NR_CYC_0   = NR_US_0 * CLK_MHZ,
  parameter int unsigned NR_CYC_1   = NR_US_1 * CLK_MHZ,
  parameter int unsigned NR_CYC_2   = NR_US_2 * CLK_MHZ,
  parameter int unsigned NR_CYC_3   = NR_US_3 * CLK_MHZ,
  parameter int unsigned RTRT_CYC_0 = RTRT_US_0 * CLK_MHZ,
  parameter int unsigned RTRT_CYC_1 = RTRT_US_1 * CLK_MHZ,
  parameter int unsigned RTRT_CYC_2 = RTRT_US_2 * CLK_MHZ,
  parameter int unsigned RTRT_CYC_3 = RTRT_US_3 * CLK_MHZ
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        master_reset_n,
  input  wire logic        global_bus_a_tx_inhibit,
  input  wire logic        global_bus_b_tx_inhibit,
  input  wire logic [9:0]  term_addr,
  input  wire logic        cmd_strobe,
  input  wire logic [15:0] cmd_word,
  input  wire logic [1:0]  mode_illegal,
  input  wire logic [1:0]  wait_start,
  input  wire logic [1:0]  wait_rtrt,
  input  wire logic [1:0]  wait_stop,
  output logic      [1:0]  cmd_accept,
  output logic      [1:0]  cmd_respond,
  output logic      [1:0]  cmd_status_only,
  output logic      [1:0]  cmd_msg_error,
  output logic      [1:0]  status_update,
  output logic      [1:0]  bcast_buffer_sel,
  output logic      [1:0]  bus_a_tx_en,
  output logic      [1:0]  bus_a_rx_en,
  output logic      [1:0]  bus_b_tx_en,
  output logic      [1:0]  bus_b_rx_en,
  output logic      [1:0]  wait_timeout
);
  import rtcfg_pkg::*;

  logic       mr_s1_q, mr_s2_q, pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q;
  logic       wr_pend_q;
  logic [7:0] wr_idx_q;
  logic [2:0] glb_q;
  logic [7:0] cfg_q [2];
  logic       addr_ok;
  logic [7:0] a_idx;

  // Master reset and global inhibit pins pass two flops before any logic reads them
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mr_s1_q <= 1'b0;
      mr_s2_q <= 1'b0;
      pa_s1_q <= 1'b0;
      pa_s2_q <= 1'b0;
      pb_s1_q <= 1'b0;
      pb_s2_q <= 1'b0;
    end
    else
    begin
      mr_s1_q <= master_reset_n;
      mr_s2_q <= mr_s1_q;
      pa_s1_q <= global_bus_a_tx_inhibit;
      pa_s2_q <= pa_s1_q;
      pb_s1_q <= global_bus_b_tx_inhibit;
      pb_s2_q <= pb_s1_q;
    end
  end

  // Zero-wait slave: address phase is taken, write lands in the data phase
  assign addr_ok = hsel && htrans[1] && hready;
  assign a_idx   = haddr[9:2];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
    end
    else
    begin
      wr_pend_q <= addr_ok && hwrite;
      wr_idx_q  <= a_idx;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_ok && !hwrite)
      begin
        if (a_idx == IDX_TERM_A && haddr[31:10] == 22'h0)
          hrdata <= {16'h0000, cfg_q[0], 8'h00};
        else if (a_idx == IDX_TERM_B && haddr[31:10] == 22'h0)
          hrdata <= {16'h0000, cfg_q[1], 8'h00};
        else if (a_idx == IDX_GLOBAL && haddr[31:10] == 22'h0)
          hrdata <= {27'h000_0000, pb_s2_q, pa_s2_q, glb_q};
        else
          hrdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      glb_q <= GLB_RESET;
    else if (wr_pend_q && wr_idx_q == IDX_GLOBAL)
      glb_q <= hwdata[2:0];
  end

  genvar t;
  generate
    for (t = 0; t < 2; t++)
    begin : g_term
      localparam logic [7:0] MY_IDX = (t == 0) ? IDX_TERM_A : IDX_TERM_B;
      logic        is_mode, undef, addr_hit, recog, bcast, inh_a, inh_b, gate_rx;
      logic [4:0]  mc;
      logic [14:0] cnt_q, limit;
      logic        run_q, rtrt_q;

      // Master reset pin clears the whole upper field, reserved bit included
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          cfg_q[t] <= CFG_RESET;
        else if (!mr_s2_q)
          cfg_q[t] <= CFG_RESET;
        else if (wr_pend_q && wr_idx_q == MY_IDX)
          cfg_q[t] <= hwdata[15:8];
      end

      assign mc      = cmd_word[4:0];
      assign is_mode = (cmd_word[9:5] == SA_MODE_LO) || (cmd_word[9:5] == SA_MODE_HI);
      // Only these undefined codes fall under the undefined-mode bit
      assign undef   = is_mode && ((!cmd_word[10] && (mc <= 5'h10 || mc == 5'h12
                       || mc == 5'h13)) || (cmd_word[10] && (mc == 5'h11
                       || mc == 5'h14 || mc == 5'h15)));
      assign bcast   = cmd_word[15:11] == BCAST_ADDR;
      assign addr_hit = (cmd_word[15:11] == term_addr[5*t +: 5] && !bcast)
                        || (bcast && !cfg_q[t][F_BC_INV]);
      assign recog   = addr_hit && !(undef && cfg_q[t][F_UMC_INV]);

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          cmd_accept[t]       <= 1'b0;
          cmd_respond[t]      <= 1'b0;
          cmd_status_only[t]  <= 1'b0;
          cmd_msg_error[t]    <= 1'b0;
          status_update[t]    <= 1'b0;
          bcast_buffer_sel[t] <= 1'b0;
        end
        else
        begin
          cmd_accept[t]      <= cmd_strobe && recog;
          cmd_respond[t]     <= cmd_strobe && recog && !bcast;
          cmd_status_only[t] <= cmd_strobe && recog && !bcast && undef
                                && mode_illegal[t];
          cmd_msg_error[t]   <= cmd_strobe && recog && undef && mode_illegal[t];
          status_update[t]   <= cmd_strobe && recog;
          if (cmd_strobe && recog)
            bcast_buffer_sel[t] <= bcast && cfg_q[t][F_SEP_BC];
        end
      end

      // Per-terminal inhibit never touches the other terminal's enables
      assign inh_a   = cfg_q[t][F_INH_A];
      assign inh_b   = cfg_q[t][F_INH_B];
      assign gate_rx = !glb_q[G_SCOPE];

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          bus_a_tx_en[t] <= 1'b0;
          bus_a_rx_en[t] <= 1'b0;
          bus_b_tx_en[t] <= 1'b0;
          bus_b_rx_en[t] <= 1'b0;
        end
        else
        begin
          bus_a_tx_en[t] <= !inh_a && !pa_s2_q && !glb_q[G_TXINH_A];
          bus_b_tx_en[t] <= !inh_b && !pb_s2_q && !glb_q[G_TXINH_B];
          bus_a_rx_en[t] <= !(inh_a && gate_rx);
          bus_b_rx_en[t] <= !(inh_b && gate_rx);
        end
      end

      // RT-RT limits already hold both embedded words, so no extra is added
      always_comb
      begin
        case ({rtrt_q, cfg_q[t][F_TO_LO +: 2]})
          3'b000:  limit = 15'(NR_CYC_0);
          3'b001:  limit = 15'(NR_CYC_1);
          3'b010:  limit = 15'(NR_CYC_2);
          3'b011:  limit = 15'(NR_CYC_3);
          3'b100:  limit = 15'(RTRT_CYC_0);
          3'b101:  limit = 15'(RTRT_CYC_1);
          3'b110:  limit = 15'(RTRT_CYC_2);
          default: limit = 15'(RTRT_CYC_3);
        endcase
      end

      // Started at mid-parity of the command, stopped at mid-sync of data
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          cnt_q           <= 15'h0000;
          run_q           <= 1'b0;
          rtrt_q          <= 1'b0;
          wait_timeout[t] <= 1'b0;
        end
        else
        begin
          wait_timeout[t] <= run_q && !wait_stop[t] && cnt_q + 15'h0001 >= limit;
          if (wait_start[t])
          begin
            cnt_q  <= 15'h0000;
            run_q  <= 1'b1;
            rtrt_q <= wait_rtrt[t];
          end
          else if (wait_stop[t] || (run_q && cnt_q + 15'h0001 >= limit))
            run_q <= 1'b0;
          else if (run_q)
            cnt_q <= cnt_q + 15'h0001;
        end
      end

      chk_umc_ignores: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_strobe && undef && cfg_q[t][F_UMC_INV] |=> !cmd_accept[t] && !status_update[t])
        else $error("undefined mode accepted while invalid");
      chk_bcast_invalid: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_strobe && bcast && cfg_q[t][F_BC_INV] |=> !cmd_accept[t])
        else $error("broadcast accepted while invalid");
      chk_bcast_valid: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_strobe && bcast && !cfg_q[t][F_BC_INV] && !undef |=> cmd_accept[t]
        && !cmd_respond[t])
        else $error("broadcast not processed");
      chk_illegal_status: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_strobe && recog && undef && mode_illegal[t] && !bcast
        |=> cmd_msg_error[t] && cmd_status_only[t])
        else $error("illegal undefined mode missed error");
      chk_sep_storage: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_strobe && recog && bcast |=> bcast_buffer_sel[t] == $past(cfg_q[t][F_SEP_BC]))
        else $error("broadcast buffer select wrong");
      chk_inhibit_a: assert property (@(posedge hclk) disable iff (!hresetn)
        inh_a [*2] |-> !bus_a_tx_en[t])
        else $error("bus A transmit not inhibited");
      chk_mr_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        !mr_s2_q |=> cfg_q[t] == CFG_RESET)
        else $error("master reset did not clear");
      chk_timeout_len: assert property (@(posedge hclk) disable iff (!hresetn)
        wait_start[t] ##1 (!wait_start[t] && !wait_stop[t]) [*3] |-> !wait_timeout[t])
        else $error("timeout far too early");
    end
  endgenerate

  chk_scope_rx: assert property (@(posedge hclk) disable iff (!hresetn)
    glb_q[G_SCOPE] && $stable(glb_q) |=> bus_a_rx_en == 2'b11 && bus_b_rx_en == 2'b11)
    else $error("receive blocked in transmit-only scope");
  chk_pin_block: assert property (@(posedge hclk) disable iff (!hresetn)
    pa_s2_q |=> bus_a_tx_en == 2'b00)
    else $error("global pin did not block bus A");
endmodule
`default_nettype wire

// ---- common/rtcfg_pkg.sv ----
`default_nettype none
package rtcfg_pkg;
  localparam int unsigned CLK_MHZ = 125;
  // Printed register indices; byte address is four times the index
  localparam logic [7:0] IDX_TERM_A = 8'h17;
  localparam logic [7:0] IDX_TERM_B = 8'h20;
  localparam logic [7:0] IDX_GLOBAL = 8'h30;
  // Field positions within the stored upper byte (register bits 15:8)
  localparam int unsigned F_TO_LO   = 6;
  localparam int unsigned F_INH_A   = 5;
  localparam int unsigned F_INH_B   = 4;
  localparam int unsigned F_BC_INV  = 3;
  localparam int unsigned F_RSVD    = 2;
  localparam int unsigned F_UMC_INV = 1;
  localparam int unsigned F_SEP_BC  = 0;
  // Global control register bits
  localparam int unsigned G_SCOPE   = 0;
  localparam int unsigned G_TXINH_A = 1;
  localparam int unsigned G_TXINH_B = 2;
  localparam int unsigned G_PIN_A   = 3;
  localparam int unsigned G_PIN_B   = 4;
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [2:0] GLB_RESET  = 3'h0;
  // Bus dead time and RT-to-RT timeout, microseconds
  localparam int unsigned NR_US_0   = 15;
  localparam int unsigned NR_US_1   = 20;
  localparam int unsigned NR_US_2   = 58;
  localparam int unsigned NR_US_3   = 138;
  localparam int unsigned RTRT_US_0 = 57;
  localparam int unsigned RTRT_US_1 = 62;
  localparam int unsigned RTRT_US_2 = 100;
  localparam int unsigned RTRT_US_3 = 180;
  // Each RT-to-RT figure already holds two embedded words of this length
  localparam int unsigned EMBED_WORD_US = 20;
  localparam logic [4:0] BCAST_ADDR = 5'h1f;
  localparam logic [4:0] SA_MODE_LO = 5'h00;
  localparam logic [4:0] SA_MODE_HI = 5'h1f;
endpackage
`default_nettype wire

// ---- dv/rtcfg_bc_model.sv ----
`default_nettype none
module rtcfg_bc_model (
  input  wire logic        hclk,
  output var  logic        cmd_strobe,
  output var  logic [15:0] cmd_word,
  output var  logic [1:0]  mode_illegal,
  output var  logic [1:0]  wait_start,
  output var  logic [1:0]  wait_rtrt,
  output var  logic [1:0]  wait_stop
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cmd_strobe = 1'b0;
    cmd_word = 16'h0000;
    mode_illegal = 2'h0;
    wait_start = 2'h0;
    wait_rtrt = 2'h0;
    wait_stop = 2'h0;
  end
  task automatic send(input logic [4:0] ad, input logic tr, input logic [4:0] sa,
                      input logic [4:0] md, input logic [1:0] ill);
    @(posedge hclk);
    cmd_strobe <= 1'b1;
    cmd_word <= {ad, tr, sa, md};
    mode_illegal <= ill;
    @(posedge hclk);
    cmd_strobe <= 1'b0;
    // Word is only valid with the strobe, so show a different value after it
    cmd_word <= ~{ad, tr, sa, md};
    mode_illegal <= ~ill;
  endtask
  task automatic start(input int t, input logic rt);
    @(posedge hclk);
    wait_start[t] <= 1'b1;
    wait_rtrt[t] <= rt;
    @(posedge hclk);
    wait_start[t] <= 1'b0;
  endtask
  // Word sync seen: ends the wait before the limit
  task automatic halt(input int t);
    @(posedge hclk);
    wait_stop[t] <= 1'b1;
    @(posedge hclk);
    wait_stop[t] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- dv/remote_terminal_config_upper_tb.sv ----
`default_nettype none
module remote_terminal_config_upper_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NR0 = 20;
  localparam int NR2 = 40;
  localparam int RT3 = 90;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [2:0]  hsize = 3'h2;
  logic [9:0]  term_addr = 10'h0c5;
  logic        master_reset_n = 1'b1;
  logic        global_bus_a_tx_inhibit = 1'b0;
  logic        global_bus_b_tx_inhibit = 1'b0;
  int          error_cnt = 0;
  int          comparisons = 0;
  wire logic [31:0] hrdata;
  wire logic        hreadyout, hresp, cmd_strobe;
  wire logic [15:0] cmd_word;
  wire logic [1:0]  mode_illegal, wait_start, wait_rtrt, wait_stop, cmd_accept, cmd_respond;
  wire logic [1:0]  cmd_status_only, cmd_msg_error, status_update, bcast_buffer_sel;
  wire logic [1:0]  bus_a_tx_en, bus_a_rx_en, bus_b_tx_en, bus_b_rx_en, wait_timeout;
  wire logic [31:0] cmd_v = {20'h0_0000, bcast_buffer_sel, cmd_accept, cmd_respond,
                             cmd_status_only, cmd_msg_error, status_update};
  wire logic [31:0] en_v = {24'h00_0000, bus_a_rx_en, bus_a_tx_en, bus_b_rx_en, bus_b_tx_en};
  rtcfg_top #(.NR_CYC_0(NR0), .NR_CYC_1(30), .NR_CYC_2(NR2), .NR_CYC_3(50),
    .RTRT_CYC_0(60), .RTRT_CYC_1(70), .RTRT_CYC_2(80), .RTRT_CYC_3(RT3)) u_rtcfg_top (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .master_reset_n,
    .global_bus_a_tx_inhibit, .global_bus_b_tx_inhibit, .term_addr, .cmd_strobe,
    .cmd_word, .mode_illegal, .wait_start, .wait_rtrt, .wait_stop, .cmd_accept, .cmd_respond,
    .cmd_status_only, .cmd_msg_error, .status_update, .bcast_buffer_sel, .bus_a_tx_en,
    .bus_a_rx_en, .bus_b_tx_en, .bus_b_rx_en, .wait_timeout);
  rtcfg_bc_model u_rtcfg_bc_model (.hclk, .cmd_strobe, .cmd_word, .mode_illegal,
    .wait_start, .wait_rtrt, .wait_stop);
  always #4 hclk = ~hclk;
  task automatic report_and_stop();
    if (error_cnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  task automatic rdy_wait();
    int i;
    i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end
    while (hreadyout !== 1'b1 && i < 50);
    if (i >= 50)
    begin
      error_cnt++;
      report_and_stop();
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    rdy_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy_wait();
    q = hrdata;
    chk(32'(hresp), 32'h0000_0000);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(a, 1'b0, 32'h0000_0000, q);
    chk(q, e);
  endtask
  task automatic cmd(input logic [4:0] ad, input logic tr, input logic [4:0] sa,
                     input logic [4:0] md, input logic [1:0] ill, input logic [31:0] e);
    u_rtcfg_bc_model.send(ad, tr, sa, md, ill);
    #1;
    chk(cmd_v, e);
  endtask
  task automatic tmr(input int t, input logic rt, input int lim);
    int n;
    n = 0;
    u_rtcfg_bc_model.start(t, rt);
    while (wait_timeout[t] !== 1'b1 && n < 300)
    begin
      @(posedge hclk);
      #1;
      n++;
    end
    if (n >= 300)
    begin
      error_cnt++;
      report_and_stop();
    end
    chk(32'(n), 32'(lim));
  endtask
  task automatic sc_regs();
    rd(8'h5c, 32'h0000_0000);
    rd(8'h80, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    wr(8'h5c, 32'h0000_fb00);
    rd(8'h5c, 32'h0000_fb00);
    rd(8'h80, 32'h0000_0000);
    wr(8'h80, 32'h0000_4a00);
    rd(8'h80, 32'h0000_4a00);
    rd(8'h5c, 32'h0000_fb00);
    master_reset_n <= 1'b0;
    cyc(5);
    rd(8'h5c, 32'h0000_0000);
    rd(8'h80, 32'h0000_0000);
    master_reset_n <= 1'b1;
    cyc(3);
  endtask
  task automatic sc_inhibit();
    wr(8'hc0, 32'h0000_0000);
    wr(8'h5c, 32'h0000_2000);
    cyc(2);
    chk(en_v, 32'h0000_00af);
    wr(8'hc0, 32'h0000_0001);
    cyc(2);
    chk(en_v, 32'h0000_00ef);
    wr(8'h5c, 32'h0000_1000);
    cyc(2);
    chk(en_v, 32'h0000_00fe);
    wr(8'h5c, 32'h0000_0000);
    global_bus_a_tx_inhibit <= 1'b1;
    cyc(5);
    chk(en_v, 32'h0000_00cf);
    rd(8'hc0, 32'h0000_0009);
    global_bus_a_tx_inhibit <= 1'b0;
    wr(8'hc0, 32'h0000_0004);
    cyc(2);
    chk(en_v, 32'h0000_00fc);
    wr(8'hc0, 32'h0000_0000);
  endtask
  task automatic sc_cmds();
    cmd(5'h06, 1'b0, 5'h00, 5'h05, 2'h2, 32'h0000_02aa);
    @(posedge hclk);
    term_addr <= 10'h0c9;
    cmd(5'h09, 1'b0, 5'h03, 5'h02, 2'h0, 32'h0000_0141);
    @(posedge hclk);
    term_addr <= 10'h0c5;
    cmd(5'h05, 1'b0, 5'h03, 5'h02, 2'h0, 32'h0000_0141);
    cmd(5'h05, 1'b0, 5'h00, 5'h05, 2'h0, 32'h0000_0141);
    cmd(5'h05, 1'b0, 5'h1f, 5'h05, 2'h1, 32'h0000_0155);
    wr(8'h5c, 32'h0000_0200);
    cmd(5'h05, 1'b0, 5'h00, 5'h05, 2'h0, 32'h0000_0000);
    cmd(5'h05, 1'b0, 5'h00, 5'h11, 2'h0, 32'h0000_0141);
    cmd(5'h05, 1'b1, 5'h00, 5'h11, 2'h0, 32'h0000_0000);
    wr(8'h5c, 32'h0000_0000);
    cmd(5'h1f, 1'b0, 5'h03, 5'h02, 2'h0, 32'h0000_0303);
    wr(8'h5c, 32'h0000_0100);
    cmd(5'h1f, 1'b0, 5'h03, 5'h02, 2'h0, 32'h0000_0703);
    wr(8'h5c, 32'h0000_0900);
    cmd(5'h1f, 1'b0, 5'h03, 5'h02, 2'h0, 32'h0000_0602);
  endtask
  task automatic sc_timer();
    int n;
    wr(8'h5c, 32'h0000_0000);
    tmr(0, 1'b0, NR0);
    tmr(1, 1'b0, NR0);
    wr(8'h5c, 32'h0000_8000);
    tmr(0, 1'b0, NR2);
    wr(8'h5c, 32'h0000_c000);
    tmr(0, 1'b1, RT3);
    // Sync seen well inside the limit: no timeout may follow
    u_rtcfg_bc_model.start(0, 1'b1);
    cyc(10);
    u_rtcfg_bc_model.halt(0);
    n = 0;
    repeat (120)
    begin
      @(posedge hclk);
      #1;
      if (wait_timeout[0] !== 1'b0)
        n++;
    end
    chk(32'(n), 32'h0000_0000);
  endtask
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(2);
    sc_regs();
    sc_inhibit();
    sc_cmds();
    sc_timer();
    report_and_stop();
  end
endmodule
`default_nettype wire
